//--- design/atr_pkg.sv
// Constants, register map and types of the alarm triggered trace recorder
package atr_pkg;
   // Clock and timing
   localparam int CLOCK_NS = 4;
   localparam int BASE_SAMPLE_NS = 250000;
   localparam int BASE_SAMPLE_CYCLES = BASE_SAMPLE_NS / CLOCK_NS;
   localparam int BASE_PER_MS = 4;
   // Record geometry
   localparam int ANALOG_CHANNELS = 7;
   localparam int ANALOG_WIDTH = 32;
   localparam int DIGITAL_CHANNELS = 8;
   localparam int SAMPLE_WIDTH = ANALOG_CHANNELS * ANALOG_WIDTH
      + DIGITAL_CHANNELS;
   localparam int RECORD_SAMPLES = 1024;
   localparam int HISTORY_ENTRIES = 16;
   localparam logic [3:0] CYCLE_SEL_MAX = 4'h000c;
   localparam logic [3:0] AUTO_CYCLE_SEL = 4'h0002;
   localparam logic [3:0] AUTO_NEAR_SEL = 4'h0000;
   localparam logic [6:0] AUTO_POSITION = 7'h005a;
   localparam logic [6:0] POSITION_MAX = 7'h0064;
   localparam logic [15:0] SWITCH_DISABLE = 16'hffff;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h0000;
   localparam logic [7:0] REG_SWITCH = 8'h0004;
   localparam logic [7:0] REG_ALARM_SEL = 8'h0008;
   localparam logic [7:0] REG_CYCLE = 8'h000c;
   localparam logic [7:0] REG_TRIG = 8'h0010;
   localparam logic [7:0] REG_LEVEL = 8'h0014;
   localparam logic [7:0] REG_POSITION = 8'h0018;
   localparam logic [7:0] REG_STATUS = 8'h001c;
   localparam logic [7:0] REG_HIST_SEL = 8'h0020;
   localparam logic [7:0] REG_HIST_ALARM = 8'h0024;
   localparam logic [7:0] REG_HIST_MON = 8'h0028;
   localparam logic [7:0] REG_HIST_CFG = 8'h002c;
   localparam logic [7:0] REG_HIST_PARAM = 8'h0030;
   localparam logic [7:0] REG_CHAN = 8'h0034;
   // Control field positions
   localparam int CTRL_MODE = 0;
   localparam int CTRL_START_LO = 1;
   localparam int CTRL_AXIS_COMMON = 3;
   localparam int CTRL_SOFT_RESET = 4;
   localparam int CTRL_CLEAR_HIST = 5;
   // Reset values
   localparam logic [15:0] SWITCH_RESET = 16'h0000;
   localparam logic [14:0] CHAN_RESET = 15'h7fff;
   // Trigger sources and start selections
   typedef enum logic [1:0] {
      TRIG_ALARM, TRIG_ANALOG, TRIG_DIGITAL, TRIG_NONE
   } atr_trig_type;
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_SINGLE = 2'h1;
   localparam logic [1:0] START_CONT = 2'h2;
endpackage

//--- design/atr_top.sv
// Alarm triggered trace recorder: sampling ring, triggers, store, history
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module atr_top #(
   parameter int BASE_CYCLES = atr_pkg::BASE_SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Amplifier status channels
   input wire logic [223:0] analog_in,
   input wire logic [7:0] digital_in,
   // Alarm events seen at this axis
   input wire logic alarm_valid,
   input wire logic [15:0] alarm_number,
   input wire logic alarm_common,
   // Auxiliary snapshot sources
   input wire logic [31:0] monitor_snapshot,
   input wire logic [31:0] config_snapshot,
   input wire logic [31:0] param_snapshot,
   // Competing tools
   input wire logic graph_active,
   input wire logic analyzer_active,
   // Axis coupling
   input wire logic peer_trigger,
   input wire logic peer_save_busy,
   output logic share_trigger,
   output logic save_busy,
   // Record storage stream
   output logic store_valid,
   input wire logic store_ready,
   output logic [3:0] store_entry,
   output logic [9:0] store_index,
   output logic [231:0] store_data,
   // Status
   output logic recording
);
   import atr_pkg::*;

   typedef enum {ST_IDLE, ST_RUN, ST_POST, ST_SAVE} atr_state_type;

   // Samples after the trigger for a position percentage
   function automatic logic [10:0] post_len(input logic [6:0] pct);
      logic [17:0] pre;
      pre = ({11'h000, pct} * 18'h0_0400) / 18'h0_0064;
      return 11'(18'h0_0400 - pre);
   endfunction

   // Settings
   atr_state_type state;
   logic soft_rst;
   logic mode_manual;
   logic [1:0] start_sel;
   logic axis_common;
   logic [15:0] switch_time;
   logic [15:0] alarm_sel;
   logic [3:0] cycle_sel;
   logic [1:0] trig_src;
   logic [2:0] trig_ach;
   logic [2:0] trig_dch;
   logic trig_pol;
   logic [31:0] trig_level;
   logic [6:0] position;
   logic [14:0] chan_en;
   logic [3:0] hist_sel;
   // Timing
   logic [31:0] base_cnt;
   logic base_tick;
   logic [1:0] ms_cnt;
   logic [11:0] cyc_cnt;
   logic sample_tick;
   logic [15:0] holdoff;
   logic graph_prev;
   // Capture
   logic [231:0] ring [RECORD_SAMPLES];
   logic [9:0] wp;
   logic [10:0] post_cnt;
   logic [10:0] save_cnt;
   logic level_prev;
   // History
   logic [19:0] hist_alarm [HISTORY_ENTRIES];
   logic [31:0] hist_mon [HISTORY_ENTRIES];
   logic [31:0] hist_cfg [HISTORY_ENTRIES];
   logic [31:0] hist_param [HISTORY_ENTRIES];
   logic [3:0] hist_wp;
   logic [4:0] hist_count;
   logic [19:0] cap_alarm;
   logic [31:0] cap_mon;
   logic [31:0] cap_cfg;
   logic [31:0] cap_param;
   // Decoded conditions
   logic rst;
   logic active;
   logic armed;
   logic settings_locked;
   logic [3:0] eff_sel;
   logic [231:0] sample;
   logic [31:0] ach_val;
   logic level_now;
   logic alarm_hit;
   logic level_hit;
   logic own_trig;
   logic peer_hit;
   logic fire;
   logic save_last;

   assign rst = !rstn || soft_rst;

   // Recorder off for disable code, tools or hold-off
   assign active = (switch_time != SWITCH_DISABLE)
      && !graph_active && !analyzer_active
      && (holdoff == 16'h0000);
   // Automatic runs by itself; manual needs a start selection
   assign armed = active && (!mode_manual || start_sel != START_STOP);
   assign settings_locked = mode_manual && start_sel != START_STOP;

   // Automatic preset cycle, shortened once the alarm is seen
   always_comb begin
      if (mode_manual) begin
         eff_sel = cycle_sel;
      end else if (state == ST_POST) begin
         eff_sel = AUTO_NEAR_SEL;
      end else begin
         eff_sel = AUTO_CYCLE_SEL;
      end
   end

   // Base 250 us tick for sampling and the millisecond hold-off divider
   always_ff @(posedge clock) begin
      if (rst) begin
         base_cnt <= 32'h0000_0000;
         base_tick <= 1'b0;
      end else if (base_cnt == 32'(BASE_CYCLES - 1)) begin
         base_cnt <= 32'h0000_0000;
         base_tick <= 1'b1;
      end else begin
         base_cnt <= base_cnt + 32'h0000_0001;
         base_tick <= 1'b0;
      end
   end

   // Sampling period of two to the selection base ticks
   always_ff @(posedge clock) begin
      if (rst) begin
         cyc_cnt <= 12'h000;
         sample_tick <= 1'b0;
      end else if (base_tick) begin
         // Twelve bits so that the 4096 tick period still fits
         if (cyc_cnt >= (12'h001 << eff_sel) - 12'h001) begin
            cyc_cnt <= 12'h000;
            sample_tick <= 1'b1;
         end else begin
            cyc_cnt <= cyc_cnt + 12'h001;
            sample_tick <= 1'b0;
         end
      end else begin
         sample_tick <= 1'b0;
      end
   end

   // Hold-off after the graph tool lets go
   always_ff @(posedge clock) begin
      if (rst) begin
         holdoff <= 16'h0000;
         ms_cnt <= 2'h0;
         graph_prev <= 1'b0;
      end else begin
         graph_prev <= graph_active;
         if (graph_prev && !graph_active
            && switch_time != SWITCH_DISABLE) begin
            holdoff <= switch_time;
            ms_cnt <= 2'h0;
         end else if (base_tick && holdoff != 16'h0000) begin
            ms_cnt <= ms_cnt + 2'h1;
            if (ms_cnt == 2'(BASE_PER_MS - 1)) begin
               holdoff <= holdoff - 16'h0001;
            end
         end
      end
   end

   // Sample word with disabled channels forced to zero in manual mode
   always_comb begin
      sample = {digital_in, analog_in};
      if (mode_manual) begin
         for (int i = 0; i < ANALOG_CHANNELS; i++) begin
            if (!chan_en[i]) begin
               sample[i*ANALOG_WIDTH +: ANALOG_WIDTH] = 32'h0000_0000;
            end
         end
         sample[231:224] = digital_in & chan_en[14:7];
      end
   end

   // Trigger sources
   assign ach_val = analog_in[trig_ach*ANALOG_WIDTH +: ANALOG_WIDTH];
   always_comb begin
      if (trig_src == TRIG_ANALOG) begin
         level_now = trig_pol ? ($signed(ach_val) >= $signed(trig_level))
            : ($signed(ach_val) <= $signed(trig_level));
      end else begin
         level_now = digital_in[trig_dch] == trig_pol;
      end
   end
   // Alarms in automatic, optionally one number, or in manual with the alarm source; alarm_valid
   // already covers common alarms, so each axis saves its own record
   assign alarm_hit = alarm_valid && (mode_manual ? trig_src == TRIG_ALARM
      : (alarm_sel == 16'h0000 || alarm_sel == alarm_number));
   // Level triggers on a rising condition, manual only
   assign level_hit = mode_manual && sample_tick && level_now && !level_prev
      && (trig_src == TRIG_ANALOG || trig_src == TRIG_DIGITAL);
   assign own_trig = alarm_hit || level_hit;
   // Peer request only when no axis is still saving
   assign peer_hit = peer_trigger && mode_manual && axis_common
      && !peer_save_busy;
   assign fire = state == ST_RUN && armed && (own_trig || peer_hit);
   assign save_last = store_valid && store_ready
      && save_cnt == 11'(RECORD_SAMPLES);

   // Share a manual trigger; alarms reach every affected axis directly
   always_ff @(posedge clock) begin
      if (rst) begin
         share_trigger <= 1'b0;
      end else begin
         share_trigger <= fire && own_trig && !alarm_hit && axis_common
            && !peer_save_busy;
      end
   end

   // Recorder sequence
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         post_cnt <= 11'h000;
         level_prev <= 1'b0;
      end else begin
         if (sample_tick) begin
            level_prev <= level_now;
         end
         case (state)
            ST_IDLE: begin
               if (armed) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!armed) begin
                  state <= ST_IDLE;
               end else if (fire) begin
                  state <= ST_POST;
                  post_cnt <= post_len(mode_manual ? position
                     : AUTO_POSITION);
               end
            end
            ST_POST: begin
               if (!active) begin
                  state <= ST_IDLE;
               end else if (post_cnt == 11'h000) begin
                  state <= ST_SAVE;
               end else if (sample_tick) begin
                  post_cnt <= post_cnt - 11'h001;
               end
            end
            ST_SAVE: begin
               if (save_last) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Ring of the last record of samples, frozen while saving
   always_ff @(posedge clock) begin
      if (rst) begin
         wp <= 10'h000;
      end else if (sample_tick && (state == ST_RUN || state == ST_POST)) begin
         wp <= wp + 10'h001;
      end
   end
   always_ff @(posedge clock) begin
      if (sample_tick && (state == ST_RUN || state == ST_POST)) begin
         ring[wp] <= sample;
      end
   end

   // Oldest-first stream of the record to storage
   always_ff @(posedge clock) begin
      if (rst) begin
         save_cnt <= 11'h000;
         store_valid <= 1'b0;
         store_index <= 10'h000;
         store_data <= '0;
      end else if (state != ST_SAVE) begin
         save_cnt <= 11'h000;
         store_valid <= 1'b0;
      end else if (!store_valid || store_ready) begin
         if (save_cnt == 11'(RECORD_SAMPLES)) begin
            store_valid <= 1'b0;
         end else begin
            store_valid <= 1'b1;
            store_index <= save_cnt[9:0];
            store_data <= ring[wp + save_cnt[9:0]];
            save_cnt <= save_cnt + 11'h001;
         end
      end
   end
   assign store_entry = hist_wp;

   // Auxiliary snapshot taken at the trigger
   always_ff @(posedge clock) begin
      if (rst) begin
         cap_alarm <= '0;
         cap_mon <= 32'h0000_0000;
         cap_cfg <= 32'h0000_0000;
         cap_param <= 32'h0000_0000;
      end else if (fire) begin
         cap_mon <= monitor_snapshot;
         cap_cfg <= config_snapshot;
         cap_param <= param_snapshot;
         if (alarm_hit) begin
            cap_alarm <= {alarm_common, TRIG_ALARM, 1'b1,
               alarm_number};
         end else begin
            cap_alarm <= {1'b0, trig_src, 1'b0, 16'h0000};
         end
      end
   end

   // History ring of records
   always_ff @(posedge clock) begin
      if (rst) begin
         hist_wp <= 4'h0;
         hist_count <= 5'h00;
      end else if (save_last) begin
         hist_wp <= hist_wp + 4'h1;
         if (hist_count != 5'(HISTORY_ENTRIES)) begin
            hist_count <= hist_count + 5'h01;
         end
      end else if (reg_write && reg_addr == REG_CTRL
         && reg_wdata[CTRL_CLEAR_HIST]) begin
         hist_count <= 5'h00;
      end
   end
   always_ff @(posedge clock) begin
      if (save_last) begin
         hist_alarm[hist_wp] <= cap_alarm;
         hist_mon[hist_wp] <= cap_mon;
         hist_cfg[hist_wp] <= cap_cfg;
         hist_param[hist_wp] <= cap_param;
      end
   end

   // Software reset pulse of one cycle, a register reset only by power-on reset
   always_ff @(posedge clock) begin
      if (!rstn) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= reg_write && reg_addr == REG_CTRL
            && reg_wdata[CTRL_SOFT_RESET];
      end
   end

   // Control register; single capture ends in stop
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_manual <= 1'b0;
         start_sel <= START_STOP;
         axis_common <= 1'b0;
         switch_time <= SWITCH_RESET;
         alarm_sel <= 16'h0000;
         hist_sel <= 4'h0;
      end else begin
         if (reg_write && reg_addr == REG_CTRL) begin
            mode_manual <= reg_wdata[CTRL_MODE];
            if (reg_wdata[CTRL_START_LO +: 2] != 2'h3) begin
               start_sel <= reg_wdata[CTRL_START_LO +: 2];
            end
            axis_common <= reg_wdata[CTRL_AXIS_COMMON];
         end else if (save_last && start_sel == START_SINGLE) begin
            start_sel <= START_STOP;
         end
         if (reg_write && reg_addr == REG_SWITCH) begin
            switch_time <= reg_wdata[15:0];
         end
         if (reg_write && reg_addr == REG_ALARM_SEL) begin
            alarm_sel <= reg_wdata[15:0];
         end
         if (reg_write && reg_addr == REG_HIST_SEL) begin
            hist_sel <= reg_wdata[3:0];
         end
      end
   end

   // Sampling settings, refused while manual sampling runs
   always_ff @(posedge clock) begin
      if (rst) begin
         cycle_sel <= 4'h0;
         trig_src <= TRIG_ALARM;
         trig_ach <= 3'h0;
         trig_dch <= 3'h0;
         trig_pol <= 1'b1;
         trig_level <= 32'h0000_0000;
         position <= AUTO_POSITION;
         chan_en <= CHAN_RESET;
      end else if (reg_write && !settings_locked) begin
         case (reg_addr)
            REG_CYCLE: begin
               cycle_sel <= (reg_wdata[3:0] > CYCLE_SEL_MAX) ? CYCLE_SEL_MAX
                  : reg_wdata[3:0];
            end
            REG_TRIG: begin
               trig_src <= (reg_wdata[1:0] == TRIG_NONE) ? TRIG_ALARM
                  : reg_wdata[1:0];
               trig_ach <= (reg_wdata[4:2] == 3'h7) ? 3'h6 : reg_wdata[4:2];
               trig_dch <= reg_wdata[7:5];
               trig_pol <= reg_wdata[8];
            end
            REG_LEVEL: begin
               trig_level <= reg_wdata;
            end
            REG_POSITION: begin
               position <= (reg_wdata[6:0] > POSITION_MAX) ? POSITION_MAX
                  : reg_wdata[6:0];
            end
            REG_CHAN: begin
               chan_en <= reg_wdata[14:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Register read, answered the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         case (reg_addr)
            REG_CTRL: reg_rdata <= {28'h000_0000, axis_common, start_sel,
               mode_manual};
            REG_SWITCH: reg_rdata <= {16'h0000, switch_time};
            REG_ALARM_SEL: reg_rdata <= {16'h0000, alarm_sel};
            REG_CYCLE: reg_rdata <= {28'h000_0000, cycle_sel};
            REG_TRIG: reg_rdata <= {23'h00_0000, trig_pol, trig_dch,
               trig_ach, trig_src};
            REG_LEVEL: reg_rdata <= trig_level;
            REG_POSITION: reg_rdata <= {25'h000_0000, position};
            REG_STATUS: reg_rdata <= {19'h0_0000, hist_count, hist_wp,
               holdoff != 16'h0000, state == ST_SAVE, state == ST_POST,
               state != ST_IDLE};
            REG_HIST_SEL: reg_rdata <= {28'h000_0000, hist_sel};
            REG_HIST_ALARM: reg_rdata <= {12'h000, hist_alarm[hist_sel]};
            REG_HIST_MON: reg_rdata <= hist_mon[hist_sel];
            REG_HIST_CFG: reg_rdata <= hist_cfg[hist_sel];
            REG_HIST_PARAM: reg_rdata <= hist_param[hist_sel];
            REG_CHAN: reg_rdata <= {17'h0_0000, chan_en};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // Status outputs
   assign save_busy = state == ST_POST || state == ST_SAVE;
   assign recording = state != ST_IDLE;
endmodule // atr_top

//--- tb/atr_top_sva.sv
// Port level assertions for the trace recorder
`timescale 1ns/1ps
module atr_top_sva #(
   parameter int BASE_CYCLES = atr_pkg::BASE_SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Competing tools
   input wire logic graph_active,
   input wire logic analyzer_active,
   // Axis coupling
   input wire logic share_trigger,
   input wire logic save_busy,
   // Record stream and status
   input wire logic store_valid,
   input wire logic store_ready,
   input wire logic [3:0] store_entry,
   input wire logic [9:0] store_index,
   input wire logic [231:0] store_data,
   input wire logic recording
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Steps of the record stream handshake
   sequence word_taken;
      store_valid && store_ready;
   endsequence
   sequence last_taken;
      word_taken ##0 store_index == 10'h3ff;
   endsequence
   // A tool in use drops the recorder to idle outside a save
   chk_tool_idle: assert property ((graph_active || analyzer_active)
      && !save_busy |-> ##[1:3] !recording)
      else $error("recorder kept running while a tool was active");
   // A stalled word is held whole
   chk_word_hold: assert property (store_valid && !store_ready |=>
      store_valid && $stable(store_data) && $stable(store_index))
      else $error("stream word changed while stalled");
   // Words leave in sample order
   chk_index_step: assert property (word_taken ##1 store_valid |->
      store_index == $past(store_index) + 10'h001)
      else $error("stream index skipped");
   // A record starts at the oldest sample
   chk_first_zero: assert property ($rose(store_valid) |->
      store_index == 10'h000)
      else $error("record did not start at index zero");
   // The last word ends the save
   chk_last_done: assert property (last_taken |=> !store_valid
      ##[0:3] !save_busy)
      else $error("save did not end after the last word");
   // Stream only flows during a save
   chk_stream_busy: assert property (store_valid |-> save_busy)
      else $error("stream word outside a save");
   // A save belongs to an active recorder
   chk_busy_rec: assert property (save_busy |-> recording)
      else $error("save while recorder idle");
   // The slot stays put within a record
   chk_slot_stable: assert property (store_valid && $past(store_valid)
      |-> $stable(store_entry))
      else $error("history slot changed inside a record");
   // Shared trigger is one pulse sent while capturing
   chk_share_pulse: assert property (share_trigger |-> save_busy
      ##1 !share_trigger)
      else $error("shared trigger malformed");
   cover property (last_taken);
endmodule // atr_top_sva

bind atr_top atr_top_sva #(.BASE_CYCLES(BASE_CYCLES)) atr_top_sva_inst (
   .clock, .rstn, .graph_active, .analyzer_active, .share_trigger,
   .save_busy, .store_valid, .store_ready, .store_entry, .store_index,
   .store_data, .recording);

//--- tb/atr_store_sink.sv
// Storage sink model that takes the record stream with random stalls
`timescale 1ns/1ps
module atr_store_sink (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Record stream
   input wire logic store_valid,
   output logic store_ready,
   input wire logic [9:0] store_index,
   // Results
   output int records,
   output int order_errors
);
   logic [9:0] next_index;
   initial store_ready = 1'h0;
   // Accept words in random bursts, count whole records
   always @(posedge clock) begin
      store_ready <= ($urandom % 4) != 0;
      if (!rstn) begin
         next_index <= 10'h000;
         records <= 0;
         order_errors <= 0;
      end else if (store_valid && store_ready) begin
         if (store_index !== next_index)
            order_errors <= order_errors + 1;
         next_index <= store_index + 10'h001;
         if (store_index == 10'h3ff)
            records <= records + 1;
      end
   end
endmodule // atr_store_sink

//--- tb/atr_top_tb.sv
// Self-checking bench for the trace recorder
`timescale 1ns/1ps
module atr_top_tb;
   import atr_pkg::*;
   logic clock = 1'h0, rstn = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic [223:0] analog_in = '0;
   logic [7:0] digital_in = 8'h00;
   logic alarm_valid = 1'h0, alarm_common = 1'h0, dig0 = 1'h0, rd_q = 1'h0;
   logic [15:0] alarm_number = 16'h0000;
   logic [31:0] monitor_snapshot = '0, config_snapshot = '0;
   logic [31:0] param_snapshot = '0;
   logic graph_active = 1'h0, analyzer_active = 1'h0;
   logic peer_trigger = 1'h0, peer_save_busy = 1'h0;
   logic share_trigger, save_busy, store_valid, store_ready, recording;
   logic [3:0] store_entry;
   logic [9:0] store_index;
   logic [231:0] store_data;
   int bad_count = 0, total_checks = 0, records, order_errors, shares = 0;
   logic [31:0] exp_q[$], mask_q[$];
   atr_top #(.BASE_CYCLES(4)) atr_top_inst (.clock, .rstn, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata, .analog_in,
      .digital_in, .alarm_valid, .alarm_number, .alarm_common,
      .monitor_snapshot, .config_snapshot, .param_snapshot, .graph_active,
      .analyzer_active, .peer_trigger, .peer_save_busy, .share_trigger,
      .save_busy, .store_valid, .store_ready, .store_entry, .store_index,
      .store_data, .recording);
   atr_store_sink atr_store_sink_inst (.clock, .rstn, .store_valid,
      .store_ready, .store_index, .records, .order_errors);
   // Clock of 4 ns
   always #2 clock = ~clock;
   // Random channel values, digital channel 0 held by the scenario
   always @(posedge clock) begin
      for (int i = 0; i < 7; i++)
         analog_in[32*i +: 32] <= $urandom;
      digital_in <= {7'($urandom), dig0};
   end
   // Compare each read answer with the oldest note
   always @(posedge clock) begin
      rd_q <= reg_read;
      if (share_trigger === 1'h1)
         shares <= shares + 1;
      if (rd_q) begin
         total_checks++;
         if ((reg_rdata & mask_q[0]) !== exp_q[0]) begin
            bad_count++;
            $display("mismatch %0t read %h want %h", $time, reg_rdata, exp_q[0]);
         end
         void'(exp_q.pop_front());
         void'(mask_q.pop_front());
      end
      // Slot of every streamed word; digital trigger kept in its record
      if (store_valid === 1'h1 && store_ready === 1'h1) begin
         total_checks++;
         if (store_entry !== 4'(records)) begin
            bad_count++;
            $display("mismatch %0t slot %h", $time, store_entry);
         end
         if (records == 1 && store_index == 10'h3ff
            && store_data[224] !== 1'h1) begin
            bad_count++;
            $display("mismatch %0t trigger sample missing", $time);
         end
      end
   end
   task automatic chk(input logic got, input logic want);
      total_checks++;
      if (got !== want) begin
         bad_count++;
         $display("mismatch %0t flag %b", $time, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clock);
      reg_write <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'h1;
      exp_q.push_back(e & m);
      mask_q.push_back(m);
      @(posedge clock);
      reg_read <= 1'h0;
   endtask
   task automatic alarm(input logic [15:0] n);
      @(posedge clock);
      alarm_valid <= 1'h1;
      alarm_number <= n;
      @(posedge clock);
      alarm_valid <= 1'h0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wait_rec(input int n);
      for (int k = 0; k < 9000 && records < n; k++)
         @(posedge clock);
      chk(records == n && order_errors == 0, 1'h1);
   endtask
   task automatic final_report;
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #380000;
      bad_count++;
      final_report;
   end
   // Main sequence
   initial begin
      void'($urandom(98));
      idle(6);
      rstn <= 1'h1;
      rd(REG_POSITION, 32'h0000_005a, 32'h0000_007f);
      rd(REG_CHAN, 32'h0000_7fff, 32'h0000_7fff);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0000_0000, 32'hffff_ffff);
      wr(REG_SWITCH, 32'h0000_ffff);
      idle(4);
      chk(recording, 1'h0);
      alarm(16'h0005);
      idle(600);
      chk(records == 0, 1'h1);
      wr(REG_SWITCH, 32'h0000_0000);
      idle(8);
      chk(recording, 1'h1);
      monitor_snapshot <= $urandom;
      config_snapshot <= $urandom;
      param_snapshot <= $urandom;
      wr(REG_ALARM_SEL, 32'h0000_0005);
      alarm(16'h0007);
      idle(200);
      chk(save_busy, 1'h0);
      alarm(16'h0005);
      idle(20);
      alarm(16'h0005);
      wait_rec(1);
      idle(40);
      wr(REG_HIST_SEL, 32'h0000_0000);
      rd(REG_HIST_ALARM, 32'h0001_0005, 32'h0007_ffff);
      rd(REG_HIST_MON, monitor_snapshot, 32'hffff_ffff);
      rd(REG_HIST_CFG, config_snapshot, 32'hffff_ffff);
      rd(REG_HIST_PARAM, param_snapshot, 32'hffff_ffff);
      rd(REG_STATUS, 32'h0000_0110, 32'h0000_1ff0);
      wr(REG_SWITCH, 32'h0000_0001);
      for (int t = 0; t < 2; t++) begin
         graph_active <= (t == 0);
         analyzer_active <= (t == 1);
         idle(6);
         chk(recording, 1'h0);
         graph_active <= 1'h0;
         analyzer_active <= 1'h0;
         idle(6);
         chk(recording, 1'(t));
         idle(24);
         chk(recording, 1'h1);
      end
      wr(REG_ALARM_SEL, 32'h0000_0000);
      wr(REG_TRIG, 32'h0000_0102);
      wr(REG_POSITION, 32'h0000_0032);
      wr(REG_CYCLE, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_000b);
      wr(REG_CYCLE, 32'h0000_0005);
      rd(REG_CYCLE, 32'h0000_0000, 32'h0000_000f);
      idle(40);
      dig0 <= 1'h1;
      wait_rec(2);
      chk(shares == 1, 1'h1);
      dig0 <= 1'h0;
      wr(REG_HIST_SEL, 32'h0000_0001);
      rd(REG_HIST_ALARM, 32'h0004_0000, 32'h0007_0000);
      rd(REG_CTRL, 32'h0000_0000, 32'h0000_0006);
      rd(REG_STATUS, 32'h0000_0220, 32'h0000_1ff0);
      wr(REG_CTRL, 32'h0000_0000);
      for (int n = 3; n <= 17; n++) begin
         alarm_common <= (n == 17);
         idle(30);
         alarm(16'(n));
         wait_rec(n);
      end
      rd(REG_STATUS, 32'h0000_1010, 32'h0000_1ff0);
      wr(REG_HIST_SEL, 32'h0000_0000);
      rd(REG_HIST_ALARM, 32'h0009_0011, 32'h000f_ffff);
      idle(4);
      final_report;
   end
endmodule // atr_top_tb
